// ==== verilog/pbs_params.svh ====
// constants for the pipelined burst sram control block
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH
`define PBS_CTL_IDLE   12'hFFF
`define PBS_MASK_ALL   4'hF
`define PBS_MASK_NONE  4'h0
`define PBS_CNT_ZERO   2'h0
`define PBS_CNT_STEP   2'h1
`define PBS_LOW_BITS   2
`endif

// ==== verilog/pbs_pkg.sv ====
// types for the pipelined burst sram control block
package pbs_pkg;
  // synchronous control pins, all as seen on the pins
  typedef struct packed {
    logic       ce1_n;   // chip_enable_primary, low active
    logic       ce2;     // chip_enable_high
    logic       ce3_n;   // chip_enable_low
    logic       pas_n;   // processor_addr_strobe
    logic       cas_n;   // controller_addr_strobe
    logic       step_n;  // burst_step, low advances
    logic       gw_n;    // global_write
    logic       ws_n;    // write_select
    logic [3:0] bw_n;    // byte_write_n, one per byte
  } pbs_ctl_t;
  typedef enum logic [2:0] {
    PBS_DESEL   = 3'b000,
    PBS_BEG_RD  = 3'b001,
    PBS_BEG_WR  = 3'b010,
    PBS_CONT_RD = 3'b011,
    PBS_CONT_WR = 3'b100,
    PBS_SUSP_RD = 3'b101,
    PBS_SUSP_WR = 3'b110,
    PBS_NOP     = 3'b111
  } pbs_cyc_t;
  typedef enum logic {
    PBS_S_IDLE  = 1'b0,
    PBS_S_BURST = 1'b1
  } pbs_state_t;
endpackage

// ==== verilog/pbs_ctrl.sv ====
// control logic of a pipelined burst sram: cycle decode, burst counter, byte writes
`timescale 1ns/100ps
`include "pbs_params.svh"
module pbs_ctrl #(
  parameter int ADDR_W = 17,  // address_inputs width
  parameter int LANE_W = 9,   // bits per byte lane
  parameter int BYTES  = 4    // byte lanes
) (
  input  wire logic                      mclk,               // 25 MHz clock
  input  wire logic                      rst_n,              // sync reset, low
  input  wire pbs_pkg::pbs_ctl_t         ctl_pins,           // clocked control pins
  input  wire logic [ADDR_W-1:0]         address_inputs,     // external address
  input  wire logic                      output_enable_n,    // async output enable
  input  wire logic                      burst_order_select, // strap, 1 interleaved
  input  wire logic [BYTES*LANE_W-1:0]   data_lanes_in,      // data pins, in
  output logic      [BYTES*LANE_W-1:0]   data_lanes_out,     // data pins, out
  output logic      [BYTES-1:0]          data_lanes_oe_n,    // low drives lane
  output logic      [ADDR_W-1:0]         array_addr,         // array address
  output logic                           array_rd,           // array read
  output logic      [BYTES-1:0]          array_we,           // array byte writes
  output logic      [BYTES*LANE_W-1:0]   array_wdata,        // array write data
  input  wire logic [BYTES*LANE_W-1:0]   array_rdata         // valid while array_rd
);
  import pbs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  pbs_ctl_t                  ctl_s1_q;
  pbs_ctl_t                  ctl_q;
  logic [ADDR_W-1:0]         addr_s1_q;
  logic [ADDR_W-1:0]         addr_q;
  logic [BYTES*LANE_W-1:0]   din_s1_q;
  logic [BYTES*LANE_W-1:0]   din_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctl_s1_q  <= `PBS_CTL_IDLE;
      ctl_q     <= `PBS_CTL_IDLE;
      addr_s1_q <= '0;
      addr_q    <= '0;
      din_s1_q  <= '0;
      din_q     <= '0;
    end
    else
    begin
      ctl_s1_q  <= ctl_pins;
      ctl_q     <= ctl_s1_q;
      addr_s1_q <= address_inputs;
      addr_q    <= addr_s1_q;
      din_s1_q  <= data_lanes_in;
      din_q     <= din_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  logic [BYTES-1:0] byte_mask;
  logic             is_write;

  assign byte_mask = !ctl_q.gw_n ? `PBS_MASK_ALL :
                     !ctl_q.ws_n ? ~ctl_q.bw_n :
                     `PBS_MASK_NONE;
  assign is_write  = (byte_mask != `PBS_MASK_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // cycle decode
  logic       ce_all;
  logic       ce_sec_off;
  logic       pas_eff;
  logic       deselect;
  logic       begin_rd;
  logic       begin_wr;
  pbs_state_t state_q;
  pbs_cyc_t   cyc;

  assign ce_all     = !ctl_q.ce1_n && ctl_q.ce2 && !ctl_q.ce3_n;
  assign ce_sec_off = !ctl_q.ce2 || ctl_q.ce3_n;
  // processor strobe is blind while primary enable is off
  assign pas_eff    = !ctl_q.pas_n && !ctl_q.ce1_n;
  assign deselect   = (!ctl_q.cas_n && ctl_q.ce1_n)
                    || (pas_eff && ce_sec_off)
                    || (!ctl_q.cas_n && ctl_q.pas_n && ce_sec_off);
  assign begin_rd   = ce_all && (!ctl_q.pas_n
                    || (!ctl_q.cas_n && !is_write));
  assign begin_wr   = ce_all && ctl_q.pas_n && !ctl_q.cas_n && is_write;
  // anything left has no strobe, or only a blind processor strobe, and steps or holds the burst
  assign cyc = deselect ? PBS_DESEL :
               begin_rd ? PBS_BEG_RD :
               begin_wr ? PBS_BEG_WR :
               (state_q != PBS_S_BURST) ? PBS_NOP :
               !ctl_q.step_n ? (is_write ? PBS_CONT_WR : PBS_CONT_RD) :
               (is_write ? PBS_SUSP_WR : PBS_SUSP_RD);

  ////////////////////////////////////////////////////////////////////////////
  // burst counter and address
  logic [ADDR_W-1:2] hi_q;
  logic [1:0]        start_q;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_nxt;
  logic [1:0]        lo_cur;
  logic [1:0]        lo_nxt;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] nxt_addr;

  assign cnt_nxt  = cnt_q + `PBS_CNT_STEP;
  // strap read straight, never registered
  assign lo_cur   = burst_order_select ? (start_q ^ cnt_q)
                                       : (start_q + cnt_q);
  assign lo_nxt   = burst_order_select ? (start_q ^ cnt_nxt)
                                       : (start_q + cnt_nxt);
  assign cur_addr = {hi_q, lo_cur};
  assign nxt_addr = {hi_q, lo_nxt};

  ////////////////////////////////////////////////////////////////////////////
  // burst state machine
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= PBS_S_IDLE;
      hi_q    <= '0;
      start_q <= `PBS_CNT_ZERO;
      cnt_q   <= `PBS_CNT_ZERO;
    end
    else
    begin
      case (cyc)
        PBS_DESEL:
        begin
          state_q <= PBS_S_IDLE;
        end
        PBS_BEG_RD, PBS_BEG_WR:
        begin
          state_q <= PBS_S_BURST;
          hi_q    <= addr_q[ADDR_W-1:`PBS_LOW_BITS];
          start_q <= addr_q[1:0];
          cnt_q   <= `PBS_CNT_ZERO;
        end
        PBS_CONT_RD, PBS_CONT_WR:
        begin
          cnt_q   <= cnt_nxt;
        end
        default:
        begin
          cnt_q   <= cnt_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array access selection
  logic              acc_rd;
  logic [BYTES-1:0]  acc_we;
  logic [ADDR_W-1:0] acc_addr;

  assign acc_rd   = (cyc == PBS_BEG_RD) || (cyc == PBS_CONT_RD) || (cyc == PBS_SUSP_RD);
  assign acc_we   = ((cyc == PBS_BEG_WR) || (cyc == PBS_CONT_WR) || (cyc == PBS_SUSP_WR))
                    ? byte_mask : `PBS_MASK_NONE;
  assign acc_addr = ((cyc == PBS_BEG_RD) || (cyc == PBS_BEG_WR)) ? addr_q :
                    ((cyc == PBS_CONT_RD) || (cyc == PBS_CONT_WR)) ? nxt_addr :
                    cur_addr;

  // array strobes registered so the array sees clean edges
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      array_addr  <= '0;
      array_rd    <= 1'b0;
      array_we    <= `PBS_MASK_NONE;
      array_wdata <= '0;
    end
    else
    begin
      array_addr  <= acc_addr;
      array_rd    <= acc_rd;
      array_we    <= acc_we;
      array_wdata <= din_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output register: read data one edge after the array access
  logic drive_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      drive_q        <= 1'b0;
      data_lanes_out <= '0;
    end
    else
    begin
      // a write or deselect leaves no pending read, so the pins float
      drive_q        <= array_rd;
      data_lanes_out <= array_rd ? array_rdata : data_lanes_out;
    end
  end

  // output enable gates drivers without a clock; a flop here would add a cycle
  genvar g;
  generate
    for (g = 0; g < BYTES; g++)
    begin : g_lane
      assign data_lanes_oe_n[g] = !(drive_q && !output_enable_n);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_read_latency: assert property ((cyc == PBS_BEG_RD) |=> array_rd ##1 drive_q)
    else $error("read data not registered two edges later");
  a_desel_float: assert property ((cyc == PBS_DESEL) |=> ##1 !drive_q)
    else $error("data driven after deselect");
  a_write_float: assert property ((array_we != `PBS_MASK_NONE) |=> !drive_q)
    else $error("data driven after a write");
  a_global_all: assert property ((cyc == PBS_BEG_WR && !ctl_q.gw_n) |=> array_we == `PBS_MASK_ALL)
    else $error("global write missed bytes");
  a_byte_select: assert property ((acc_we != `PBS_MASK_NONE && ctl_q.gw_n)
                                  |=> array_we == ~$past(ctl_q.bw_n))
    else $error("byte write mask wrong");
  a_no_byte_read: assert property ((ctl_q.gw_n && !ctl_q.ws_n && &ctl_q.bw_n && ce_all
                                    && !ctl_q.cas_n && ctl_q.pas_n) |=> array_rd)
    else $error("no byte strobe should be a read");
  a_begin_load: assert property ((begin_wr && !deselect)
                                 |=> array_addr == $past(addr_q) && cnt_q == `PBS_CNT_ZERO)
    else $error("begin write did not load address");
  a_lin_step: assert property ((cyc == PBS_CONT_RD && !burst_order_select)
                               |=> array_addr[1:0] == $past(start_q + cnt_q + 2'h1))
    else $error("linear step wrong");
  a_ilv_step: assert property ((cyc == PBS_CONT_WR && burst_order_select)
                               |=> array_addr[1:0] == $past(start_q ^ cnt_nxt))
    else $error("interleaved step wrong");
  a_susp_hold: assert property ((cyc == PBS_SUSP_RD) |=> array_addr == $past(cur_addr)
                                && $stable(cnt_q))
    else $error("suspend moved the address");
  a_hi_fixed: assert property ((state_q == PBS_S_BURST && ctl_q.cas_n && !pas_eff)
                               |=> $stable(hi_q))
    else $error("upper address moved in burst");
  a_oe_blocks: assert property (output_enable_n |-> &data_lanes_oe_n)
    else $error("driving with output enable high");

  ////////////////////////////////////////////////////////////////////////////
  // write bursts: a suspend rewrites the same address with the new mask
  a_susp_rewrite: assert property ((cyc == PBS_SUSP_WR)
                                   |=> array_we == $past(byte_mask) && array_addr == $past(cur_addr))
    else $error("suspended write did not rewrite current address");

  // a continued write leaves no read behind, so the lanes stay released
  a_cont_float: assert property ((cyc == PBS_CONT_WR)
                                 |=> ##1 !drive_q)
    else $error("data driven during write burst");

  // a continued read must reach the output register
  a_cont_drive: assert property ((cyc == PBS_CONT_RD)
                                 |=> ##1 drive_q)
    else $error("continued read not presented");

  // counter rolls over inside the four-word block
  a_wrap_four: assert property (((cyc == PBS_CONT_RD) || (cyc == PBS_CONT_WR)) && (&cnt_q)
                                |=> cnt_q == `PBS_CNT_ZERO)
    else $error("burst counter did not wrap");

  // processor strobe alone with primary off must not start anything
  a_pas_blind: assert property ((ctl_q.ce1_n && !ctl_q.pas_n && ctl_q.cas_n && state_q == PBS_S_IDLE)
                                |=> !array_rd && array_we == `PBS_MASK_NONE)
    else $error("processor strobe acted with primary enable off");

  // controller strobe with primary off is a deselect, no access
  a_cas_desel: assert property ((!ctl_q.cas_n && ctl_q.ce1_n)
                                |=> !array_rd && array_we == `PBS_MASK_NONE)
    else $error("access while deselected by controller strobe");

  // secondary enables gate the processor strobe as well
  a_sec_off: assert property ((!ctl_q.ce1_n && !ctl_q.pas_n && ce_sec_off)
                              |=> !array_rd && array_we == `PBS_MASK_NONE)
    else $error("access with a secondary enable inactive");

  // processor strobe with all enables on always reads, whatever the write strobes
  a_pas_read: assert property ((ce_all && !ctl_q.pas_n)
                               |=> array_rd && array_we == `PBS_MASK_NONE)
    else $error("processor strobe did not begin a read");

  // output register only moves on a read
  a_out_hold: assert property ((!array_rd)
                               |=> $stable(data_lanes_out))
    else $error("read data changed without a read");

  // controller strobe with both write strobes high is a read
  a_plain_read: assert property ((ctl_q.gw_n && ctl_q.ws_n && ce_all && ctl_q.pas_n && !ctl_q.cas_n)
                                 |=> array_rd)
    else $error("no write signalled yet no read");

  // begin write carries the mask and the data of the same pin cycle
  a_begin_write: assert property (begin_wr
                                  |=> array_we == $past(byte_mask) && array_wdata == $past(din_q))
    else $error("begin write mask or data wrong");

  // deselect always closes the burst
  a_desel_idle: assert property ((cyc == PBS_DESEL)
                                 |=> state_q == PBS_S_IDLE)
    else $error("deselect left the burst open");

  ////////////////////////////////////////////////////////////////////////////
  // scenarios worth seeing
  c_byte_write: cover property (cyc == PBS_BEG_WR && ctl_q.gw_n);

  c_read_burst: cover property ((cyc == PBS_BEG_RD) ##1 (cyc == PBS_CONT_RD) [*3]);
  c_write_susp: cover property ((cyc == PBS_BEG_WR) ##1 (cyc == PBS_SUSP_WR));
  c_abort: cover property ((cyc == PBS_CONT_RD) ##1 (cyc == PBS_BEG_WR));
  c_ilv_wrap: cover property (burst_order_select && cyc == PBS_CONT_RD && cnt_q == 2'h3);
endmodule

// ==== dv/pbs_host.sv ====
// host model driving burst cycles onto the sram control pins
`timescale 1ns/100ps
`include "pbs_params.svh"
module pbs_host
  import pbs_pkg::*;
(
  input  wire logic   mclk,               // pin clock
  output pbs_ctl_t    ctl_pins,           // clocked control pins
  output logic [16:0] address_inputs,     // lowest bits carry burst start
  output logic        output_enable_n,    // async output enable
  output logic        burst_order_select, // strap
  output logic [35:0] data_lanes_in       // write data
);
  // pins idle at time zero
  initial
  begin
    ctl_pins = `PBS_CTL_IDLE;
    address_inputs = 17'h0;
    output_enable_n = 1'b1;
    burst_order_select = 1'b0;
    data_lanes_in = 36'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one pin cycle; writes keep output enable high so the bus stays ours
  task automatic cyc(input pbs_ctl_t c, input logic [16:0] a, input logic [35:0] d, input logic oe_n);
    logic wr;
    wr = !c.gw_n || (!c.ws_n && c.bw_n != 4'hF);
    ctl_pins <= c;
    address_inputs <= a;
    output_enable_n <= oe_n || wr;
    data_lanes_in <= wr ? d : ~data_lanes_in; // released lanes never hold a value
    @(posedge mclk);
  endtask
  // strap only moves while no burst is open
  task automatic strap(input logic v);
    burst_order_select <= v;
  endtask
endmodule

// ==== dv/pipelined_burst_sram_control_tb.sv ====
// self-checking bench for the pipelined burst sram control block
`timescale 1ns/100ps
`include "pbs_params.svh"
module pipelined_burst_sram_control_tb;
  import pbs_pkg::*;
  logic        mclk;
  logic        rst_n;
  pbs_ctl_t    ctl_pins;
  logic [16:0] address_inputs;
  logic        output_enable_n;
  logic        burst_order_select;
  logic [35:0] data_lanes_in;
  logic [35:0] data_lanes_out;
  logic [3:0]  data_lanes_oe_n;
  logic [16:0] array_addr;
  logic        array_rd;
  logic [3:0]  array_we;
  logic [35:0] array_wdata;
  logic [35:0] array_rdata;
  logic [57:0] exp_q[$];
  logic [57:0] obs;
  logic [16:0] rd_a;
  logic        rd_v = 1'b0;
  int          errors;
  int          num_checks;
  int          oe_low;
  logic [31:0] rnd;
  logic [16:0] keep_a;
  // deselect cases: primary off, low-enable off, high-enable off, both with the controller strobe
  pbs_ctl_t    desel[5] = '{12'hD7F, 12'h6FF, 12'h0FF, 12'h77F, 12'h17F};
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // array content differs for every address
  function automatic logic [35:0] pat(input logic [16:0] a);
    return {a, ~a, 2'h3};
  endfunction
  function automatic logic [3:0] wmask(input pbs_ctl_t c);
    return !c.gw_n ? 4'hF : (!c.ws_n ? ~c.bw_n : 4'h0);
  endfunction
  function automatic logic [57:0] acc(input logic [16:0] a, input logic [3:0] we, input logic [35:0] d);
    return {we == 4'h0, a, we, we == 4'h0 ? 36'h0 : d};
  endfunction
  task automatic check(input logic [57:0] got, input logic [57:0] want);
    num_checks++;
    if (got !== want)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // start cycle, n steps, one suspend; steps past four wrap inside the block
  task automatic burst(input pbs_ctl_t c, input logic [16:0] a, input int n, input logic oe);
    logic [1:0]  lo;
    logic [35:0] d;
    int          k;
    d = {rnd[3:0], rnd};
    rnd = lfsr(rnd);
    pbs_host_inst.cyc(c, a, d, oe);
    exp_q.push_back(acc(a, wmask(c), d));
    c[8:6] = 3'b110;
    for (int i = 1; i <= n + 1; i++)
    begin
      k = (i > n) ? n : i;
      c.step_n = (i > n);
      d = {rnd[3:0], rnd};
      rnd = lfsr(rnd);
      lo = burst_order_select ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      pbs_host_inst.cyc(c, a, d, oe);
      exp_q.push_back(acc({a[16:2], lo}, wmask(c), d));
    end
  endtask
  // deselect ends the burst, idle cycles then do nothing
  task automatic flush();
    pbs_host_inst.cyc(desel[0], 17'h0, 36'h0, 1'b1);
    repeat (5) pbs_host_inst.cyc(`PBS_CTL_IDLE, 17'h0, 36'h0, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  assign array_rdata = pat(array_addr);
  assign obs = {array_rd, array_addr, array_we, array_we == 4'h0 ? 36'h0 : array_wdata};
  // every array access is matched in order against the expected list
  always @(posedge mclk)
  begin
    if (rd_v)
      check(data_lanes_out, pat(rd_a));
    rd_v = rst_n && array_rd;
    rd_a = array_addr;
    if (rst_n && data_lanes_oe_n != 4'hF)
    begin
      oe_low++;
      check(output_enable_n, 1'b0);
    end
    if (rst_n && (array_rd || array_we != 4'h0))
      check(obs, exp_q.size() == 0 ? 58'h0 : exp_q.pop_front());
  end
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // generous bound; the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    errors++;
    summarize();
  end
  initial
  begin
    errors = 0;
    num_checks = 0;
    oe_low = 0;
    rnd = 32'he11c24cc;
    rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      pbs_host_inst.strap(s[0]);
      burst(12'h4FF, rnd[16:0], 4, s[1]);
      flush();
      burst(12'h55F, rnd[20:4], 4, 1'b1);
      flush();
      burst(pbs_ctl_t'(12'h560 | {8'h0, rnd[3:0]}), rnd[24:8], 2, 1'b1);
      flush();
    end
    for (int v = 0; v < 5; v++)
    begin
      burst(12'h4FF, rnd[16:0], 1, 1'b0);
      pbs_host_inst.cyc(desel[v], 17'h0, 36'h0, 1'b0);
      pbs_host_inst.cyc(12'h5BF, 17'h0, 36'h0, 1'b0);
      flush();
    end
    // processor strobe with primary off continues, controller strobe aborts
    // burst moves rnd on, so the start address is kept for the expectation
    keep_a = rnd[16:0];
    burst(12'h4FF, keep_a, 1, 1'b0);
    pbs_host_inst.cyc(12'hCBF, 17'h0, 36'h0, 1'b0);
    exp_q.push_back(acc({keep_a[16:2], keep_a[1:0] + 2'h2}, 4'h0, 36'h0));
    burst(12'h57F, rnd[27:11], 1, 1'b0);
    flush();
    check(exp_q.size(), 58'h0);
    check(oe_low != 0, 58'h1);
    summarize();
  end
  pbs_host pbs_host_inst (
    .mclk               (mclk),
    .ctl_pins           (ctl_pins),
    .address_inputs     (address_inputs),
    .output_enable_n    (output_enable_n),
    .burst_order_select (burst_order_select),
    .data_lanes_in      (data_lanes_in)
  );
  pbs_ctrl pbs_ctrl_inst (
    .mclk               (mclk),
    .rst_n              (rst_n),
    .ctl_pins           (ctl_pins),
    .address_inputs     (address_inputs),
    .output_enable_n    (output_enable_n),
    .burst_order_select (burst_order_select),
    .data_lanes_in      (data_lanes_in),
    .data_lanes_out     (data_lanes_out),
    .data_lanes_oe_n    (data_lanes_oe_n),
    .array_addr         (array_addr),
    .array_rd           (array_rd),
    .array_we           (array_we),
    .array_wdata        (array_wdata),
    .array_rdata        (array_rdata)
  );
endmodule
